// File: rtl/bfie_pkg.sv
/*
 * Constants, opcodes and register map of the bit/flag execution unit.
 * Assumes an AXI4-Lite master with 32-bit data and a single 25 MHz clock.
 */
package bfie_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] CMD_OFS = 12'h000;
    localparam logic [11:0] FLAGS_OFS = 12'h004;
    localparam logic [11:0] EXTW_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS = 12'h00c;
    localparam logic [11:0] RF_BASE = 12'h100;
    localparam logic [11:0] IO_BASE = 12'h200;
    localparam logic [3:0] RF_PAGE = 4'h1;
    localparam logic [3:0] IO_PAGE = 4'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [3:0] EXTW_RST = 4'h2;
    // Command word fields
    localparam int OP_LSB = 0;
    localparam int REG_LSB = 5;
    localparam int BIT_LSB = 10;
    localparam int IOA_LSB = 13;
    localparam int LIST_LSB = 19;
    localparam int SRAM_BIT = 21;
    // Status flag positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_T = 6;
    localparam int F_I = 7;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ROTL = 5'h01, OP_ROTR = 5'h02, OP_SHRA = 5'h03,
        OP_SWAP = 5'h04, OP_FSET = 5'h05, OP_FCLR = 5'h06, OP_IOSET = 5'h07,
        OP_IOCLR = 5'h08, OP_TSTORE = 5'h09, OP_TLOAD = 5'h0a, OP_MEM = 5'h0b,
        OP_SEC = 5'h0c, OP_CLC = 5'h0d, OP_SEN = 5'h0e, OP_CLN = 5'h0f,
        OP_SEZ = 5'h10, OP_CLZ = 5'h11, OP_SEI = 5'h12, OP_CLI = 5'h13,
        OP_SSET = 5'h14, OP_SCLR = 5'h15, OP_VSET = 5'h16, OP_VCLR = 5'h17,
        OP_SET = 5'h18, OP_CLT = 5'h19, OP_HSET = 5'h1a, OP_HCLR = 5'h1b
    } bfie_op_type;
    localparam logic [4:0] OP_DED_FIRST = 5'h0c;
    localparam logic [4:0] OP_DED_LAST = 5'h1b;
    localparam logic [4:0] SRAM_EXTRA = 5'h01;

    // Flag index of a dedicated set/clear pair, in opcode order
    function automatic logic [2:0] ded_flag(input logic [4:0] op);
        logic [2:0] pair;
        pair = 3'((op - OP_DED_FIRST) >> 1);
        case (pair)
            3'h0: ded_flag = 3'(F_C);
            3'h1: ded_flag = 3'(F_N);
            3'h2: ded_flag = 3'(F_Z);
            3'h3: ded_flag = 3'(F_I);
            3'h4: ded_flag = 3'(F_S);
            3'h5: ded_flag = 3'(F_V);
            3'h6: ded_flag = 3'(F_T);
            default: ded_flag = 3'(F_H);
        endcase
    endfunction : ded_flag
endpackage : bfie_pkg

// File: rtl/bfie_shift_unit.sv
/*
 * Combinational result and flag logic for rotate, shift, swap, bit transfer and flag ops.
 * Assumes the caller registers the outputs and gates them with its own execute strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module bfie_shift_unit
    import bfie_pkg::*;
(
    input wire logic [4:0] op,         // Operation code
    input wire logic [7:0] rd,         // Register operand
    input wire logic [2:0] bit_idx,    // Bit or flag index
    input wire logic [7:0] flags_in,   // Current status flags
    output logic [7:0] res,            // Register result
    output logic res_we,               // Result goes back to the register
    output logic [7:0] flags_out       // Next status flags
);
    logic [7:0] f;
    always_comb begin
        res = rd;
        res_we = 1'b0;
        f = flags_in;
        case (op)
            OP_ROTL: begin
                res = {rd[6:0], flags_in[F_C]};
                res_we = 1'b1;
                f[F_C] = rd[7];
                f[F_H] = rd[3];
            end
            OP_ROTR: begin
                res = {flags_in[F_C], rd[7:1]};
                res_we = 1'b1;
                f[F_C] = rd[0];
            end
            OP_SHRA: begin
                res = {rd[7], rd[7:1]};
                res_we = 1'b1;
                f[F_C] = rd[0];
            end
            OP_SWAP: begin
                res = {rd[3:0], rd[7:4]};
                res_we = 1'b1;
            end
            OP_FSET: f[bit_idx] = 1'b1;
            OP_FCLR: f[bit_idx] = 1'b0;
            OP_TSTORE: f[F_T] = rd[bit_idx];
            OP_TLOAD: begin
                res[bit_idx] = flags_in[F_T];
                res_we = 1'b1;
            end
            default: begin
                // Dedicated pairs: even opcode sets, odd clears
                if (op >= OP_DED_FIRST && op <= OP_DED_LAST) begin
                    f[ded_flag(op)] = ~op[0];
                end
            end
        endcase
        if (op == OP_ROTL || op == OP_ROTR || op == OP_SHRA) begin
            f[F_Z] = (res == 8'h00);
            f[F_N] = res[7];
            f[F_V] = res[7] ^ f[F_C];
        end
        flags_out = f;
    end
endmodule : bfie_shift_unit
`default_nettype wire

// File: rtl/bfie_exec_top.sv
/*
 * Bit/flag execution unit with register file, I/O space, status flags and
 * memory-access timing, reached over an AXI4-Lite slave port.
 * Assumes one clock, synchronous active-low reset and a well-behaved master.
 */
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module bfie_exec_top
    import bfie_pkg::*;
(
    input wire logic aclk,                 // 25 MHz clock
    input wire logic aresetn,              // Synchronous reset, active low
    input wire logic awvalid,              // Write address valid
    output logic awready,                  // Write address ready
    input wire logic [ADDR_W-1:0] awaddr,  // Write address
    input wire logic [2:0] awprot,         // Unused protection
    input wire logic wvalid,               // Write data valid
    output logic wready,                   // Write data ready
    input wire logic [31:0] wdata,         // Write data
    input wire logic [3:0] wstrb,          // Write strobes
    output logic bvalid,                   // Write response valid
    input wire logic bready,               // Write response ready
    output logic [1:0] bresp,              // Write response
    input wire logic arvalid,              // Read address valid
    output logic arready,                  // Read address ready
    input wire logic [ADDR_W-1:0] araddr,  // Read address
    input wire logic [2:0] arprot,         // Unused protection
    output logic rvalid,                   // Read data valid
    input wire logic rready,               // Read data ready
    output logic [31:0] rdata,             // Read data
    output logic [1:0] rresp,              // Read response
    output logic [7:0] status_flags,       // Status flags register
    output logic busy                      // Memory access still counting
);
    logic [7:0] rf_q [32];
    logic [7:0] io_q [64];
    logic [7:0] flags_q;
    logic [3:0] extw_q;
    logic [4:0] cnt_q;
    logic [4:0] last_cycles_q;
    logic busy_q;
    logic aw_ok_q, w_ok_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Register page and word index of a byte address
    function automatic logic [3:0] page_of(input logic [ADDR_W-1:0] a);
        page_of = a[11:8];
    endfunction : page_of

    function automatic logic [5:0] word_of(input logic [ADDR_W-1:0] a);
        word_of = a[7:2];
    endfunction : word_of

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == CMD_OFS) || (a == FLAGS_OFS) || (a == EXTW_OFS) ||
            (a == STAT_OFS) || (a[1:0] == 2'h0 && page_of(a) == IO_PAGE) ||
            (a[1:0] == 2'h0 && page_of(a) == RF_PAGE && !a[7]);
    endfunction : is_mapped

    // Command fields come from the held write data
    logic [4:0] cmd_op;
    logic [4:0] cmd_reg;
    logic [2:0] cmd_bit;
    logic [5:0] cmd_ioa;
    logic [1:0] cmd_list;
    logic cmd_sram;
    assign cmd_op = w_data_q[OP_LSB +: 5];
    assign cmd_reg = w_data_q[REG_LSB +: 5];
    assign cmd_bit = w_data_q[BIT_LSB +: 3];
    assign cmd_ioa = w_data_q[IOA_LSB +: 6];
    assign cmd_list = w_data_q[LIST_LSB +: 2];
    assign cmd_sram = w_data_q[SRAM_BIT];

    // A write commits once both halves are held; a busy unit stalls writes, not reads
    logic wr_fire, exec, wr_ok, wr_lane0;
    assign wr_fire = aw_ok_q && w_ok_q && !bvalid_q && !busy_q;
    assign exec = wr_fire && aw_addr_q == CMD_OFS && w_strb_q[0];
    assign wr_ok = is_mapped(aw_addr_q);
    assign wr_lane0 = wr_fire && w_strb_q[0];

    logic [7:0] rd_val, unit_res, unit_flags;
    logic unit_we;
    assign rd_val = rf_q[cmd_reg];

    bfie_shift_unit bfie_shift_unit_inst (
        .op(cmd_op),
        .rd(rd_val),
        .bit_idx(cmd_bit),
        .flags_in(flags_q),
        .res(unit_res),
        .res_we(unit_we),
        .flags_out(unit_flags)
    );

    // Cycles of a data memory access, listed count plus memory penalty
    logic [4:0] mem_cycles;
    always_comb begin
        if (cmd_sram) begin
            mem_cycles = 5'(cmd_list) + SRAM_EXTRA;
        end else begin
            mem_cycles = 5'(cmd_list) + 5'(extw_q);
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_q <= 1'b0;
            aw_addr_q <= '0;
            awready_q <= 1'b1;
        end else if (awvalid && awready_q) begin
            aw_ok_q <= 1'b1;
            aw_addr_q <= awaddr;
            awready_q <= 1'b0;
        end else if (wr_fire) begin
            aw_ok_q <= 1'b0;
        end else if (bvalid_q && bready) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_ok_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            wready_q <= 1'b1;
        end else if (wvalid && wready_q) begin
            w_ok_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready_q <= 1'b0;
        end else if (wr_fire) begin
            w_ok_q <= 1'b0;
        end else if (bvalid_q && bready) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register file: bus writes and operation results share one port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= 8'h00;
            end
        end else if (exec && unit_we) begin
            rf_q[cmd_reg] <= unit_res;
        end else if (wr_lane0 && wr_ok && page_of(aw_addr_q) == RF_PAGE) begin
            rf_q[5'(word_of(aw_addr_q))] <= w_data_q[7:0];
        end
    end

    // I/O space: single-bit ops touch only the addressed bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 64; i++) begin
                io_q[i] <= 8'h00;
            end
        end else if (exec && cmd_op == OP_IOSET) begin
            io_q[cmd_ioa][cmd_bit] <= 1'b1;
        end else if (exec && cmd_op == OP_IOCLR) begin
            io_q[cmd_ioa][cmd_bit] <= 1'b0;
        end else if (wr_lane0 && wr_ok && page_of(aw_addr_q) == IO_PAGE) begin
            io_q[word_of(aw_addr_q)] <= w_data_q[7:0];
        end
    end

    // I/O and memory ops pass the flags through the unit unchanged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= FLAGS_RST;
        end else if (exec) begin
            flags_q <= unit_flags;
        end else if (wr_lane0 && aw_addr_q == FLAGS_OFS) begin
            flags_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            extw_q <= EXTW_RST;
        end else if (wr_lane0 && aw_addr_q == EXTW_OFS) begin
            extw_q <= w_data_q[3:0];
        end
    end

    // Busy spans exactly the access cycles; the commit edge is the first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            last_cycles_q <= 5'h00;
        end else if (exec && cmd_op == OP_MEM) begin
            // Zero-cycle access must not wrap the counter into a long busy
            cnt_q <= (mem_cycles > 5'h01) ? mem_cycles - 5'h01 : 5'h00;
            busy_q <= mem_cycles > 5'h01;
            last_cycles_q <= mem_cycles;
        end else if (exec) begin
            last_cycles_q <= 5'h01;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
            busy_q <= cnt_q > 5'h01;
        end
    end

    // Read channel, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= 32'h0000_0000;
            if (araddr == FLAGS_OFS) begin
                rdata_q[7:0] <= flags_q;
            end else if (araddr == EXTW_OFS) begin
                rdata_q[3:0] <= extw_q;
            end else if (araddr == STAT_OFS) begin
                rdata_q[0] <= busy_q;
                rdata_q[12:8] <= last_cycles_q;
            end else if (is_mapped(araddr) && page_of(araddr) == RF_PAGE) begin
                rdata_q[7:0] <= rf_q[5'(word_of(araddr))];
            end else if (is_mapped(araddr) && page_of(araddr) == IO_PAGE) begin
                rdata_q[7:0] <= io_q[word_of(araddr)];
            end
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign status_flags = flags_q;
    assign busy = busy_q;

    rotl_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_ROTL |=> rf_q[$past(cmd_reg)] ==
        {$past(rd_val[6:0]), $past(flags_q[F_C])} && flags_q[F_C] == $past(rd_val[7])
        && flags_q[F_H] == $past(rd_val[3]))
        else $error("rotate left result or carry wrong");
    rotr_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_ROTR |=> rf_q[$past(cmd_reg)] ==
        {$past(flags_q[F_C]), $past(rd_val[7:1])} && flags_q[F_C] == $past(rd_val[0])
        && flags_q[F_V] == (flags_q[F_N] ^ flags_q[F_C]))
        else $error("rotate right result or flags wrong");
    io_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_IOSET |=> io_q[$past(cmd_ioa)] ==
        ($past(io_q[cmd_ioa]) | (8'h01 << $past(cmd_bit))) && $stable(flags_q))
        else $error("I/O bit set wrong");
    io_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_IOCLR |=> io_q[$past(cmd_ioa)] ==
        ($past(io_q[cmd_ioa]) & ~(8'h01 << $past(cmd_bit))) && $stable(flags_q))
        else $error("I/O bit clear wrong");
    bit_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_TSTORE |=> flags_q[F_T] == $past(rd_val[cmd_bit])
        && (flags_q & 8'hbf) == ($past(flags_q) & 8'hbf))
        else $error("bit store wrong");
    bit_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_TLOAD |=> rf_q[$past(cmd_reg)][$past(cmd_bit)] ==
        $past(flags_q[F_T]) && $stable(flags_q))
        else $error("bit load wrong");
    ovf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd_op == OP_VSET || cmd_op == OP_VCLR) |=>
        flags_q == (($past(flags_q) & 8'hf7) | {4'h0, $past(cmd_op == OP_VSET), 3'h0}))
        else $error("overflow flag op wrong");
    half_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd_op == OP_HSET || cmd_op == OP_HCLR) |=>
        flags_q == (($past(flags_q) & 8'hdf) | {2'h0, $past(cmd_op == OP_HSET), 5'h00}))
        else $error("half-carry flag op wrong");
    sign_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd_op == OP_SSET || cmd_op == OP_SCLR) |=>
        flags_q == (($past(flags_q) & 8'hef) | {3'h0, $past(cmd_op == OP_SSET), 4'h0}))
        else $error("signed test flag op wrong");
    sram_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_MEM && cmd_sram && cmd_list == 2'h2 |=>
        busy_q [*2] ##1 !busy_q)
        else $error("internal SRAM access length wrong");
    shra_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_SHRA |=> rf_q[$past(cmd_reg)] ==
        {$past(rd_val[7]), $past(rd_val[7:1])} && flags_q[F_C] == $past(rd_val[0]))
        else $error("arithmetic shift wrong");
    swap_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_SWAP |=> rf_q[$past(cmd_reg)] ==
        {$past(rd_val[3:0]), $past(rd_val[7:4])} && $stable(flags_q))
        else $error("nibble swap wrong");
    idx_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd_op == OP_FSET |=>
        flags_q == ($past(flags_q) | (8'h01 << $past(cmd_bit))))
        else $error("indexed flag set wrong");
endmodule : bfie_exec_top
`default_nettype wire

// File: tb/bfie_axi_master.sv
/*
 * Bus master model that drives the execution unit's register port.
 * Assumes wr and rd are called one at a time, never before reset ends.
 */
`timescale 1ns/10ps
`default_nettype none
module bfie_axi_master
    import bfie_pkg::*;
(
    input wire logic aclk,                // Clock
    output logic awvalid,                 // AW valid
    input wire logic awready,             // AW ready
    output logic [ADDR_W-1:0] awaddr,     // AW address
    output logic [2:0] awprot,            // AW protection
    output logic wvalid,                  // W valid
    input wire logic wready,              // W ready
    output logic [31:0] wdata,            // W data
    output logic [3:0] wstrb,             // W strobes
    input wire logic bvalid,              // B valid
    output logic bready,                  // B ready
    input wire logic [1:0] bresp,         // B response
    output logic arvalid,                 // AR valid
    input wire logic arready,             // AR ready
    output logic [ADDR_W-1:0] araddr,     // AR address
    output logic [2:0] arprot,            // AR protection
    input wire logic rvalid,              // R valid
    output logic rready,                  // R ready
    input wire logic [31:0] rdata,        // R data
    input wire logic [1:0] rresp          // R response
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    end

    // Released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : bfie_axi_master
`default_nettype wire

// File: tb/test_bit_flag_instruction_exec.sv
/*
 * Self-checking bench for the bit/flag execution unit.
 * Assumes the package and the bus master model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_bit_flag_instruction_exec
    import bfie_pkg::*;
();
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, busy;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] status_flags;
    int fails = 0, checked = 0, cyc = 0, busy_cnt = 0;

    bfie_exec_top bfie_exec_top_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .status_flags, .busy);
    bfie_axi_master bfie_axi_master_inst (.aclk, .awvalid, .awready, .awaddr, .awprot,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot, .rvalid, .rready, .rdata, .rresp);

    initial aclk = 1'b0;
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (busy === 1'b1) busy_cnt++;
        if (cyc == 6000) begin
            fails++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        bfie_axi_master_inst.wr(a, {24'h000000, d}, r);
        `CHK(r, RESP_OKAY)
    endtask : wreg

    task automatic rd32(input logic [11:0] a, output logic [31:0] d);
        logic [1:0] r;
        bfie_axi_master_inst.rd(a, d, r);
        `CHK(r, RESP_OKAY)
    endtask : rd32

    task automatic cmd(input logic [4:0] op, input logic [4:0] rg, input logic [2:0] b,
                       input logic [5:0] io, input logic [1:0] ls, input logic sr);
        logic [1:0] r;
        wreg(CMD_OFS, 8'h00);
        bfie_axi_master_inst.wr(CMD_OFS, {10'h000, sr, ls, io, b, rg, op}, r);
        `CHK(r, RESP_OKAY)
    endtask : cmd

    // Expected {flags, result}; S, T and I never move on shifts
    function automatic logic [15:0] exp_shift(input logic [4:0] op, input logic [7:0] d,
                                              input logic [7:0] f);
        logic [7:0] r;
        logic c;
        r = {d[3:0], d[7:4]};
        c = f[0];
        if (op == OP_ROTL) begin r = {d[6:0], f[0]}; c = d[7]; f[5] = d[3]; end
        if (op == OP_ROTR) begin r = {f[0], d[7:1]}; c = d[0]; end
        if (op == OP_SHRA) begin r = {d[7], d[7:1]}; c = d[0]; end
        if (op != OP_SWAP) f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        return {f, r};
    endfunction : exp_shift

    task automatic t_shift();
        logic [4:0] ops [4] = '{OP_ROTL, OP_ROTR, OP_SHRA, OP_SWAP};
        logic [7:0] v [3] = '{8'h96, 8'h01, 8'h88};
        logic [31:0] d;
        logic [15:0] e;
        for (int i = 0; i < 12; i++) for (int c = 0; c < 2; c++) begin
            wreg(12'h10c, v[i % 3]);
            wreg(FLAGS_OFS, {7'h28, c[0]});
            cmd(ops[i / 3], 5'h03, 3'h0, 6'h00, 2'h0, 1'b0);
            e = exp_shift(ops[i / 3], v[i % 3], {7'h28, c[0]});
            `CHK(status_flags, e[15:8])
            rd32(12'h10c, d);
            `CHK(d, {24'h000000, e[7:0]})
        end
        $display("test shift done");
    endtask : t_shift

    task automatic t_io_transfer();
        logic [31:0] d;
        wreg(12'h214, 8'h5a);
        wreg(FLAGS_OFS, 8'ha5);
        cmd(OP_IOSET, 5'h00, 3'h0, 6'h05, 2'h0, 1'b0);
        cmd(OP_IOCLR, 5'h00, 3'h6, 6'h05, 2'h0, 1'b0);
        rd32(12'h214, d);
        `CHK(d, 32'h0000001b)
        cmd(OP_IOSET, 5'h00, 3'h7, 6'h3f, 2'h0, 1'b0);
        rd32(12'h2fc, d);
        `CHK(d, 32'h00000080)
        `CHK(status_flags, 8'ha5)
        wreg(12'h11c, 8'h10);
        cmd(OP_TSTORE, 5'h07, 3'h4, 6'h00, 2'h0, 1'b0);
        `CHK(status_flags, 8'he5)
        cmd(OP_TSTORE, 5'h07, 3'h3, 6'h00, 2'h0, 1'b0);
        `CHK(status_flags, 8'ha5)
        wreg(FLAGS_OFS, 8'h4f);
        cmd(OP_TLOAD, 5'h1f, 3'h7, 6'h00, 2'h0, 1'b0);
        rd32(12'h17c, d);
        `CHK(d, 32'h00000080)
        `CHK(status_flags, 8'h4f)
        $display("test io and transfer done");
    endtask : t_io_transfer

    task automatic t_flags();
        logic [2:0] idx [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};
        logic [7:0] m;
        for (int k = 0; k < 32; k++) begin
            m = 8'h01 << (k < 16 ? idx[k / 2] : 3'(k / 2));
            wreg(FLAGS_OFS, k[0] ? 8'hff : 8'h00);
            cmd(k < 16 ? 5'(12 + k) : (k[0] ? OP_FCLR : OP_FSET), 5'h00, 3'(k / 2), 6'h00,
                2'h0, 1'b0);
            `CHK(status_flags, k[0] ? ~m : m)
        end
        $display("test flags done");
    endtask : t_flags

    task automatic t_mem();
        logic [31:0] d;
        logic [1:0] r;
        int exp_cyc [4] = '{3, 4, 6, 0};
        logic [1:0] ls [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
        for (int i = 0; i < 4; i++) begin
            if (i >= 2) wreg(EXTW_OFS, i == 2 ? 8'h05 : 8'h00);
            busy_cnt = 0;
            cmd(OP_MEM, 5'h00, 3'h0, 6'h00, ls[i], i == 0);
            repeat (8) @(posedge aclk);
            `CHK(busy_cnt, exp_cyc[i] > 1 ? exp_cyc[i] - 1 : 0)
            rd32(STAT_OFS, d);
            `CHK(d[12:8], 5'(exp_cyc[i]))
        end
        bfie_axi_master_inst.rd(12'h010, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h00000000})
        $display("test memory timing done");
    endtask : t_mem

    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_shift();
        t_io_transfer();
        t_flags();
        t_mem();
        print_verdict();
    end
endmodule : test_bit_flag_instruction_exec
`default_nettype wire
